// file: verilog/adcsq_pkg.sv
// Shared constants and carrier types of the converter sequencer control block.
package adcsq_pkg;

	// Bus geometry.
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int NUM_INPUTS = 8;
	localparam int RES_W = 12;

	// Register byte offsets.
	localparam logic [5:0] OFS_CONV_CONTROL = 6'h00;
	localparam logic [5:0] OFS_TRIGGER_INPUT_SELECT = 6'h02;
	localparam logic [5:0] OFS_CONV_CONFIG = 6'h04;
	localparam logic [5:0] OFS_IRQ_FLAGS = 6'h06;
	localparam logic [5:0] OFS_IRQ_ENABLES = 6'h08;
	localparam logic [5:0] OFS_INPUT_RESULT_BASE = 6'h10;
	localparam logic [5:0] OFS_INPUT_RESULT_LAST = 6'h1e;

	// Control register field positions.
	localparam int POS_CUR_INPUT_LSB = 12;
	localparam int POS_BUSY = 10;
	localparam int POS_START = 1;
	localparam int POS_MODULE_ENABLE = 0;

	// Trigger and input select field positions.
	localparam int POS_LAST_INPUT_LSB = 11;
	localparam int POS_FIRST_INPUT_LSB = 8;
	localparam int POS_ALIGN = 7;
	localparam int POS_SCAN_MODE = 6;
	localparam int POS_TRIG_SEL_LSB = 4;
	localparam int POS_SAMPLE_LSB = 0;

	// Configuration and flag field positions.
	localparam int POS_VOLTAGE_RANGE_SELECT_LSB = 0;
	localparam int POS_OVERWRITE_LSB = 8;
	localparam int POS_COMPLETION_LSB = 0;

	// Reset values.
	localparam logic [2:0] RST_SAMPLE_TIME = 3'h7;
	localparam logic [2:0] RST_INPUT = 3'h0;
	localparam logic [1:0] RST_TRIG_SEL = 2'h0;
	localparam logic [1:0] RST_VOLTAGE_RANGE_SELECT = 2'h0;
	localparam logic [11:0] RST_RESULT = 12'h000;
	localparam logic [15:0] RST_READ_DATA = 16'h0000;

	// Timing: sampling length is the field value plus this many converter clocks.
	localparam logic [3:0] SAMPLE_BASE_CYCLES = 4'h4;

	// Highest implemented input; a stop after it shows input zero.
	localparam logic [2:0] MAX_INPUT = 3'h7;
	localparam logic [1:0] VOLTAGE_RANGE_SELECT_OFF = 2'h0;

	// Trigger source encodings.
	typedef enum logic [1:0] {
		ADCSQ_TRIG_SOFTWARE = 2'b00,
		ADCSQ_TRIG_TIMER = 2'b01,
		ADCSQ_TRIG_RESERVED = 2'b10,
		ADCSQ_TRIG_EXTERNAL = 2'b11
	} adcsq_trig_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		ADCSQ_ST_IDLE = 2'b00,
		ADCSQ_ST_LAUNCH = 2'b01,
		ADCSQ_ST_CONVERT = 2'b10
	} adcsq_state_t;

	// Request to the analog core.
	typedef struct packed {
		logic start;
		logic [2:0] channel;
		logic [3:0] sample_cycles;
	} adcsq_core_req_t;

	// Answer from the analog core.
	typedef struct packed {
		logic done;
		logic [11:0] data;
	} adcsq_core_rsp_t;

endpackage

// file: verilog/adcsq_trig.sv
// Trigger source selection and external pin edge detection.
`timescale 1ns/1ns
module adcsq_trig (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Selection and arming.
	input wire logic [1:0] i_trig_sel,
	input wire logic i_armed,
	input wire logic i_sw_go,
	// Trigger sources.
	input wire logic i_timer_underflow,
	input wire logic i_external_trigger_pin_n,
	// Resulting trigger pulse.
	output logic o_trigger
);

	logic pin_prev_ff;

	// The pin idles high, so reset to high to avoid a false edge after reset.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pin_prev_ff <= 1'b1;
		end else begin
			pin_prev_ff <= i_external_trigger_pin_n;
		end
	end

	// The reserved code selects nothing, so it never triggers.
	always_comb begin
		case (adcsq_pkg::adcsq_trig_t'(i_trig_sel))
			adcsq_pkg::ADCSQ_TRIG_SOFTWARE: o_trigger = i_sw_go;
			adcsq_pkg::ADCSQ_TRIG_TIMER: o_trigger = i_armed & i_timer_underflow;
			adcsq_pkg::ADCSQ_TRIG_EXTERNAL: begin
				o_trigger = i_armed & pin_prev_ff & ~i_external_trigger_pin_n;
			end
			default: o_trigger = 1'b0;
		endcase
	end

endmodule // adcsq_trig

// file: verilog/adcsq_flags.sv
// Per-input completion and overwrite flags with write-one-to-clear.
`timescale 1ns/1ns
module adcsq_flags (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Result loads, one bit per input.
	input wire logic [7:0] i_load,
	// Software clears, one bit per input.
	input wire logic [7:0] i_clr_completion,
	input wire logic [7:0] i_clr_overwrite,
	// Flag state.
	output logic [7:0] o_completion,
	output logic [7:0] o_overwrite
);

	// A load in the same cycle as a clear wins, so no event is lost.
	for (genvar m = 0; m < adcsq_pkg::NUM_INPUTS; m++) begin : g_flag
		always_ff @(posedge i_clock) begin
			if (i_rst) begin
				o_completion[m] <= 1'b0;
			end else if (i_load[m]) begin
				o_completion[m] <= 1'b1;
			end else if (i_clr_completion[m]) begin
				o_completion[m] <= 1'b0;
			end
		end

		// Only the completion flag decides the error, never a read of the result.
		always_ff @(posedge i_clock) begin
			if (i_rst) begin
				o_overwrite[m] <= 1'b0;
			end else if (i_load[m] & o_completion[m]) begin
				o_overwrite[m] <= 1'b1;
			end else if (i_clr_overwrite[m]) begin
				o_overwrite[m] <= 1'b0;
			end
		end
	end

endmodule // adcsq_flags

// file: verilog/adcsq_ctrl.sv
// Sequencer, register file and result storage of the converter control block.
`timescale 1ns/1ns

// Functional notes
// - Result load sets that input's completion flag.
// - Load while completion set sets overwrite flag.
// - Overwrite error never stops the scan.
// - Overwrite ignores whether result was read.
// - Interrupt only for enabled, set flags.
// - Flags in 15-8/7-0, write one clears.
// - Bits 14-12 show input being converted.
// - After stop show last input; highest shows zero.
// - Busy bit 10 high while converting.
// - Start bit starts or arms; zero stops later.
// - Start bit never clears itself.
// - Module enable gates clock; terminate first.
// - Alignment bit picks left or right justify.
// - Alignment change re-justifies reads instantly.
// - Bit 6 selects continuous or one-time.
// - Bits 5-4 choose software, timer, external trigger.
// - Sampling length is field plus four.
// - Voltage range zero blocks conversion.
// - Eight read-only results, reset to zero.
// - Triggers accepted only while idle.
// - Inputs converted first to last ascending.
// - One-time stops after range; continuous repeats.
// - External pin falling edge starts when armed.
module adcsq_ctrl (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Register port.
	input wire logic [5:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// Trigger sources.
	input wire logic i_timer_underflow,
	input wire logic i_external_trigger_pin_n,
	// Analog core.
	output adcsq_pkg::adcsq_core_req_t o_core_req,
	input wire adcsq_pkg::adcsq_core_rsp_t i_core_rsp,
	output logic o_core_clock_en,
	// Interrupt request.
	output logic o_irq
);

	// Software visible settings.
	logic conv_start_ff;
	logic module_enable_ff;
	logic [2:0] last_input_select_ff;
	logic [2:0] first_input_select_ff;
	logic result_alignment_ff;
	logic scan_mode_ff;
	logic [1:0] trigger_select_ff;
	logic [2:0] sample_time_select_ff;
	logic [1:0] voltage_range_select_ff;
	logic [7:0] overwrite_irq_enable_ff;
	logic [7:0] completion_irq_enable_ff;

	// Sequencer state.
	adcsq_pkg::adcsq_state_t state_ff;
	adcsq_pkg::adcsq_state_t nxt_state;
	logic [2:0] current_input_status_ff;
	logic [2:0] nxt_current_input;
	logic sw_used_ff;
	logic [11:0] result_value_ff [8];

	// Bus side signals.
	logic wr_ctl;
	logic wr_trg;
	logic wr_cfg;
	logic wr_flags;
	logic wr_enables;
	logic [15:0] nxt_rdata;
	logic [2:0] rd_index;

	// Flag and trigger signals.
	logic [7:0] load_onehot;
	logic [7:0] completion_flag;
	logic [7:0] overwrite_flag;
	logic trigger;
	logic conv_busy_status;
	logic can_run;
	logic last_of_range;
	logic keep_going;

	// Write decode; strobes are never both high.
	assign wr_ctl = i_wr & (i_addr == adcsq_pkg::OFS_CONV_CONTROL);
	assign wr_trg = i_wr & (i_addr == adcsq_pkg::OFS_TRIGGER_INPUT_SELECT);
	assign wr_cfg = i_wr & (i_addr == adcsq_pkg::OFS_CONV_CONFIG);
	assign wr_flags = i_wr & (i_addr == adcsq_pkg::OFS_IRQ_FLAGS);
	assign wr_enables = i_wr & (i_addr == adcsq_pkg::OFS_IRQ_ENABLES);

	// Busy is any non-idle state.
	assign conv_busy_status = (state_ff != adcsq_pkg::ADCSQ_ST_IDLE);

	// Conversion needs the module on and a usable voltage range.
	assign can_run = module_enable_ff
		& (voltage_range_select_ff != adcsq_pkg::VOLTAGE_RANGE_SELECT_OFF);

	// Control register. The start bit only changes by software writes.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			conv_start_ff <= 1'b0;
			module_enable_ff <= 1'b0;
		end else if (wr_ctl) begin
			conv_start_ff <= i_wdata[adcsq_pkg::POS_START];
			module_enable_ff <= i_wdata[adcsq_pkg::POS_MODULE_ENABLE];
		end
	end

	// Trigger and input select register; software keeps it still while busy.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			last_input_select_ff <= adcsq_pkg::RST_INPUT;
			first_input_select_ff <= adcsq_pkg::RST_INPUT;
			result_alignment_ff <= 1'b0;
			scan_mode_ff <= 1'b0;
			trigger_select_ff <= adcsq_pkg::RST_TRIG_SEL;
			sample_time_select_ff <= adcsq_pkg::RST_SAMPLE_TIME;
		end else if (wr_trg) begin
			last_input_select_ff <= i_wdata[adcsq_pkg::POS_LAST_INPUT_LSB +: 3];
			first_input_select_ff <= i_wdata[adcsq_pkg::POS_FIRST_INPUT_LSB +: 3];
			result_alignment_ff <= i_wdata[adcsq_pkg::POS_ALIGN];
			scan_mode_ff <= i_wdata[adcsq_pkg::POS_SCAN_MODE];
			trigger_select_ff <= i_wdata[adcsq_pkg::POS_TRIG_SEL_LSB +: 2];
			sample_time_select_ff <= i_wdata[adcsq_pkg::POS_SAMPLE_LSB +: 3];
		end
	end

	// Configuration register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			voltage_range_select_ff <= adcsq_pkg::RST_VOLTAGE_RANGE_SELECT;
		end else if (wr_cfg) begin
			voltage_range_select_ff <= i_wdata[adcsq_pkg::POS_VOLTAGE_RANGE_SELECT_LSB +: 2];
		end
	end

	// Interrupt enable register.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			overwrite_irq_enable_ff <= 8'h00;
			completion_irq_enable_ff <= 8'h00;
		end else if (wr_enables) begin
			overwrite_irq_enable_ff <= i_wdata[adcsq_pkg::POS_OVERWRITE_LSB +: 8];
			completion_irq_enable_ff <= i_wdata[adcsq_pkg::POS_COMPLETION_LSB +: 8];
		end
	end

	// A software start is used once until the start bit is written zero.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sw_used_ff <= 1'b0;
		end else if (!conv_start_ff) begin
			sw_used_ff <= 1'b0;
		end else if (trigger && !conv_busy_status) begin
			sw_used_ff <= 1'b1;
		end
	end

	// Trigger selection and external edge detection.
	adcsq_trig u_trig (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_trig_sel(trigger_select_ff),
		.i_armed(conv_start_ff),
		.i_sw_go(conv_start_ff & ~sw_used_ff),
		.i_timer_underflow(i_timer_underflow),
		.i_external_trigger_pin_n(i_external_trigger_pin_n),
		.o_trigger(trigger)
	);

	// The scan ends at the last input; the range is trusted to be ordered.
	assign last_of_range = (current_input_status_ff == last_input_select_ff);

	// Continue only while started, enabled and, at range end, in continuous mode.
	assign keep_going = conv_start_ff & can_run & (~last_of_range | scan_mode_ff);

	// Sequencer next state. Overwrite errors play no part here.
	always_comb begin
		nxt_state = state_ff;
		nxt_current_input = current_input_status_ff;
		case (state_ff)
			adcsq_pkg::ADCSQ_ST_IDLE: begin
				if (trigger && can_run) begin
					nxt_state = adcsq_pkg::ADCSQ_ST_LAUNCH;
					nxt_current_input = first_input_select_ff;
				end
			end
			adcsq_pkg::ADCSQ_ST_LAUNCH: begin
				nxt_state = adcsq_pkg::ADCSQ_ST_CONVERT;
			end
			adcsq_pkg::ADCSQ_ST_CONVERT: begin
				if (i_core_rsp.done) begin
					if (keep_going) begin
						nxt_state = adcsq_pkg::ADCSQ_ST_LAUNCH;
						if (last_of_range) begin
							nxt_current_input = first_input_select_ff;
						end else begin
							nxt_current_input = current_input_status_ff + 3'h1;
						end
					end else begin
						nxt_state = adcsq_pkg::ADCSQ_ST_IDLE;
						if (current_input_status_ff == adcsq_pkg::MAX_INPUT) begin
							nxt_current_input = adcsq_pkg::RST_INPUT;
						end
					end
				end
			end
			default: begin
				nxt_state = adcsq_pkg::ADCSQ_ST_IDLE;
			end
		endcase
	end

	// Sequencer state registers.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_ff <= adcsq_pkg::ADCSQ_ST_IDLE;
			current_input_status_ff <= adcsq_pkg::RST_INPUT;
		end else begin
			state_ff <= nxt_state;
			current_input_status_ff <= nxt_current_input;
		end
	end

	// Core request: one-cycle start pulse with channel and sampling length.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_core_req <= '0;
		end else begin
			o_core_req.start <= (nxt_state == adcsq_pkg::ADCSQ_ST_LAUNCH);
			o_core_req.channel <= nxt_current_input;
			o_core_req.sample_cycles <= {1'b0, sample_time_select_ff}
				+ adcsq_pkg::SAMPLE_BASE_CYCLES;
		end
	end

	// The core clock runs while enabled and until a running scan ends,
	// so clearing the enable lets the current conversion terminate.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_core_clock_en <= 1'b0;
		end else begin
			o_core_clock_en <= module_enable_ff | conv_busy_status;
		end
	end

	// One-hot load strobe for the input whose result arrives.
	for (genvar m = 0; m < adcsq_pkg::NUM_INPUTS; m++) begin : g_result
		assign load_onehot[m] = i_core_rsp.done
			& (state_ff == adcsq_pkg::ADCSQ_ST_CONVERT)
			& (current_input_status_ff == 3'(m));

		// Results are stored raw; justification is applied only on read.
		always_ff @(posedge i_clock) begin
			if (i_rst) begin
				result_value_ff[m] <= adcsq_pkg::RST_RESULT;
			end else if (load_onehot[m]) begin
				result_value_ff[m] <= i_core_rsp.data;
			end
		end
	end

	// Flag bank; write one clears, set wins over a clear in the same cycle.
	adcsq_flags u_flags (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_load(load_onehot),
		.i_clr_completion(wr_flags ? i_wdata[adcsq_pkg::POS_COMPLETION_LSB +: 8] : 8'h00),
		.i_clr_overwrite(wr_flags ? i_wdata[adcsq_pkg::POS_OVERWRITE_LSB +: 8] : 8'h00),
		.o_completion(completion_flag),
		.o_overwrite(overwrite_flag)
	);

	// Registered interrupt so the output is glitch free.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |({overwrite_flag, completion_flag}
				& {overwrite_irq_enable_ff, completion_irq_enable_ff});
		end
	end

	// Result index from the word address.
	assign rd_index = i_addr[3:1];

	// Read mux; reserved bits and unmapped addresses read zero.
	always_comb begin
		nxt_rdata = 16'h0000;
		if (i_addr == adcsq_pkg::OFS_CONV_CONTROL) begin
			nxt_rdata[adcsq_pkg::POS_CUR_INPUT_LSB +: 3] = current_input_status_ff;
			nxt_rdata[adcsq_pkg::POS_BUSY] = conv_busy_status;
			nxt_rdata[adcsq_pkg::POS_START] = conv_start_ff;
			nxt_rdata[adcsq_pkg::POS_MODULE_ENABLE] = module_enable_ff;
		end else if (i_addr == adcsq_pkg::OFS_TRIGGER_INPUT_SELECT) begin
			nxt_rdata[adcsq_pkg::POS_LAST_INPUT_LSB +: 3] = last_input_select_ff;
			nxt_rdata[adcsq_pkg::POS_FIRST_INPUT_LSB +: 3] = first_input_select_ff;
			nxt_rdata[adcsq_pkg::POS_ALIGN] = result_alignment_ff;
			nxt_rdata[adcsq_pkg::POS_SCAN_MODE] = scan_mode_ff;
			nxt_rdata[adcsq_pkg::POS_TRIG_SEL_LSB +: 2] = trigger_select_ff;
			nxt_rdata[adcsq_pkg::POS_SAMPLE_LSB +: 3] = sample_time_select_ff;
		end else if (i_addr == adcsq_pkg::OFS_CONV_CONFIG) begin
			nxt_rdata[adcsq_pkg::POS_VOLTAGE_RANGE_SELECT_LSB +: 2] = voltage_range_select_ff;
		end else if (i_addr == adcsq_pkg::OFS_IRQ_FLAGS) begin
			nxt_rdata = {overwrite_flag, completion_flag};
		end else if (i_addr == adcsq_pkg::OFS_IRQ_ENABLES) begin
			nxt_rdata = {overwrite_irq_enable_ff, completion_irq_enable_ff};
		end else if ((i_addr >= adcsq_pkg::OFS_INPUT_RESULT_BASE)
			&& (i_addr <= adcsq_pkg::OFS_INPUT_RESULT_LAST) && !i_addr[0]) begin
			if (result_alignment_ff) begin
				nxt_rdata = {result_value_ff[rd_index], 4'h0};
			end else begin
				nxt_rdata = {4'h0, result_value_ff[rd_index]};
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rdata <= adcsq_pkg::RST_READ_DATA;
		end else if (i_rd) begin
			o_rdata <= nxt_rdata;
		end else begin
			o_rdata <= adcsq_pkg::RST_READ_DATA;
		end
	end

endmodule // adcsq_ctrl

// file: tb/adcsq_assertions.sv
// Concurrent port checks for the converter sequencer control block.
`timescale 1ns/1ns
module adcsq_assertions (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Register port.
	input wire logic [5:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] o_rdata,
	// Trigger sources.
	input wire logic i_timer_underflow,
	input wire logic i_external_trigger_pin_n,
	// Analog core.
	input wire adcsq_pkg::adcsq_core_req_t o_core_req,
	input wire adcsq_pkg::adcsq_core_rsp_t i_core_rsp,
	input wire logic o_core_clock_en,
	// Interrupt request.
	input wire logic o_irq
);
	// One clock domain, so clocking and reset are declared once.
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);

	// Reserved control bits read as zero beside the status fields.
	ctl_reserved_a: assert property (
		i_rd && i_addr == adcsq_pkg::OFS_CONV_CONTROL |=>
		o_rdata[15] == 1'b0 && o_rdata[11] == 1'b0 && o_rdata[9:2] == 8'h00)
		else $error("control reserved bits not zero");
	// Only the range field of the configuration register can read as one.
	cfg_reserved_a: assert property (
		i_rd && i_addr == adcsq_pkg::OFS_CONV_CONFIG |=> o_rdata[15:2] == 14'h0000)
		else $error("configuration reserved bits not zero");
	// A result read is justified to one side, so four bits at one end are zero.
	result_align_a: assert property (
		i_rd && i_addr >= adcsq_pkg::OFS_INPUT_RESULT_BASE &&
		i_addr <= adcsq_pkg::OFS_INPUT_RESULT_LAST |=>
		o_rdata[15:12] == 4'h0 || o_rdata[3:0] == 4'h0)
		else $error("result word not justified");
	// Requests are single pulses with a conversion between them.
	req_gap_a: assert property (o_core_req.start |=> !o_core_req.start [*2])
		else $error("core request pulses too close");
	// The input number moves only with a new request, or to zero after a stop at the top input.
	chan_hold_a: assert property (
		$changed(o_core_req.channel) |-> o_core_req.start ||
		(o_core_req.channel == 3'h0 && $past(o_core_req.channel) == adcsq_pkg::MAX_INPUT))
		else $error("channel changed without a request");
	// Sampling length is the field plus four, so it lies in four to eleven.
	sample_range_a: assert property (
		o_core_req.start |-> o_core_req.sample_cycles >= 4'h4 &&
		o_core_req.sample_cycles <= 4'hb)
		else $error("sampling length out of range");
	// The converter clock runs whenever a request goes out.
	clken_req_a: assert property (o_core_req.start |-> o_core_clock_en)
		else $error("request with converter clock stopped");
	// Clearing every flag with no load nearby drops the request two cycles on.
	flag_clear_a: assert property (
		i_wr && i_addr == adcsq_pkg::OFS_IRQ_FLAGS && i_wdata == 16'hffff &&
		!i_core_rsp.done && !$past(i_core_rsp.done) |-> ##2 !o_irq)
		else $error("interrupt held after all flags cleared");
	// With every enable off no request can be raised.
	irq_mask_a: assert property (
		i_wr && i_addr == adcsq_pkg::OFS_IRQ_ENABLES && i_wdata == 16'h0000 |-> ##2 !o_irq)
		else $error("interrupt raised with all enables off");
endmodule // adcsq_assertions

bind adcsq_ctrl adcsq_assertions adcsq_assertions_inst (
	.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_underflow(i_timer_underflow),
	.i_external_trigger_pin_n(i_external_trigger_pin_n), .o_core_req(o_core_req),
	.i_core_rsp(i_core_rsp), .o_core_clock_en(o_core_clock_en), .o_irq(o_irq)
);

// file: tb/adcsq_core_model.sv
// Behavioural sampler and converter core that answers the sequencer.
`timescale 1ns/1ns
module adcsq_core_model (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst,
	// Core link.
	input wire adcsq_pkg::adcsq_core_req_t i_req,
	output adcsq_pkg::adcsq_core_rsp_t o_rsp,
	// Pace control and record of answers.
	input wire logic i_slow,
	output logic [7:0][11:0] o_log
);
	logic [4:0] wait_ff;
	logic conv_ff;
	logic [7:0] cnt_ff;

	// One answer per request; a running count makes every load differ.
	// Between answers the data lines wander so stale data never look valid.
	always_ff @(posedge i_clock) begin
		o_rsp.done <= 1'b0;
		o_rsp.data <= ~o_rsp.data;
		if (i_rst) begin
			conv_ff <= 1'b0;
			cnt_ff <= 8'h00;
			o_rsp.data <= 12'h000;
		end else if (i_req.start) begin
			conv_ff <= 1'b1;
			wait_ff <= i_slow ? 5'h14 : 5'h01; // Slow mode stands for a long sample.
		end else if (conv_ff && wait_ff != 5'h00) begin
			wait_ff <= wait_ff - 5'h01;
		end else if (conv_ff) begin
			conv_ff <= 1'b0;
			cnt_ff <= cnt_ff + 8'h01;
			o_rsp.done <= 1'b1;
			o_rsp.data <= {i_req.channel, 1'b1, cnt_ff};
			o_log[i_req.channel] <= {i_req.channel, 1'b1, cnt_ff};
		end
	end
endmodule // adcsq_core_model

// file: tb/testbench.sv
// Self-checking bench for the converter sequencer control block.
`timescale 1ns/1ns
module testbench;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [5:0] i_addr = 6'h00;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_timer_underflow = 1'b0;
	logic ext_pin_n = 1'b1;
	logic slow = 1'b0;
	logic [15:0] o_rdata;
	logic o_core_clock_en;
	logic o_irq;
	adcsq_pkg::adcsq_core_req_t core_req;
	adcsq_pkg::adcsq_core_rsp_t core_rsp;
	logic [7:0][11:0] log_data;
	logic [2:0] seen [$];
	logic [3:0] smp;
	logic [15:0] v;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;

	// Clock at 250 MHz.
	always #2 i_clock = ~i_clock;

	adcsq_ctrl adcsq_ctrl_inst (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_timer_underflow(i_timer_underflow), .i_external_trigger_pin_n(ext_pin_n),
		.o_core_req(core_req), .i_core_rsp(core_rsp), .o_core_clock_en(o_core_clock_en),
		.o_irq(o_irq));
	adcsq_core_model adcsq_core_model_inst (.i_clock(i_clock), .i_rst(i_rst),
		.i_req(core_req), .o_rsp(core_rsp), .i_slow(slow), .o_log(log_data));

	// Records each request to the core and cuts a hang short.
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (core_req.start === 1'b1) begin
			seen.push_back(core_req.channel);
			smp <= core_req.sample_cycles;
		end
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			conclude();
		end
	end

	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so take them mid-cycle.
	task automatic rd(input logic [5:0] a);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		v = o_rdata;
	endtask

	task automatic rdc(input logic [5:0] a, input logic [15:0] e, input string n);
		rd(a);
		chk(n, e, v);
	endtask

	function automatic logic [5:0] ra(input int m);
		return adcsq_pkg::OFS_INPUT_RESULT_BASE + 6'(2 * m);
	endfunction

	task automatic wait_starts(input int n);
		for (int i = 0; i < 2000 && seen.size() < n; i++)
			@(posedge i_clock);
		chk("request count", 16'(n), 16'(seen.size()));
	endtask

	// Polls the busy bit, since the start bit says nothing about activity.
	task automatic wait_idle();
		for (int i = 0; i < 300; i++) begin
			rd(adcsq_pkg::OFS_CONV_CONTROL);
			if (v[10] === 1'b0)
				return;
		end
		chk("busy", 16'h0000, 16'(v[10]));
	endtask

	task automatic pulse_timer();
		@(posedge i_clock);
		i_timer_underflow <= 1'b1;
		@(posedge i_clock);
		i_timer_underflow <= 1'b0;
	endtask

	task automatic t_reset();
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h7400);
		rdc(adcsq_pkg::OFS_CONV_CONTROL, 16'h0000, "control");
		rdc(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h0007, "input select");
		rdc(adcsq_pkg::OFS_CONV_CONFIG, 16'h0000, "config");
		rdc(adcsq_pkg::OFS_IRQ_FLAGS, 16'h0000, "flags");
		rdc(adcsq_pkg::OFS_IRQ_ENABLES, 16'h0000, "enables");
		rdc(6'h0a, 16'h0000, "unmapped");
		for (int m = 0; m < 8; m++) begin
			wr(ra(m), 16'hffff);
			rdc(ra(m), 16'h0000, "result");
		end
	endtask

	// Software trigger, one pass over inputs two to four.
	task automatic t_one_shot();
		seen.delete();
		wr(adcsq_pkg::OFS_CONV_CONFIG, 16'h0001);
		wr(adcsq_pkg::OFS_IRQ_ENABLES, 16'h00ff);
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h2203);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		wait_starts(3);
		wait_idle();
		repeat (20) @(posedge i_clock);
		chk("request count", 16'h0003, 16'(seen.size()));
		for (int m = 0; m < 3; m++)
			chk("channel", 16'(m + 2), 16'(seen[m]));
		chk("sample", 16'h0007, 16'(smp));
		rdc(adcsq_pkg::OFS_CONV_CONTROL, 16'h4003, "control");
		rdc(adcsq_pkg::OFS_IRQ_FLAGS, 16'h001c, "flags");
		chk("irq", 16'h0001, 16'(o_irq));
		for (int m = 2; m < 5; m++)
			rdc(ra(m), {4'h0, log_data[m]}, "result");
	endtask

	// Rerun with flags still set, then left justify, partial clear and masking.
	task automatic t_overwrite();
		seen.delete();
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0001);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		wait_starts(1);
		rd(ra(2));
		wait_starts(3);
		wait_idle();
		rdc(adcsq_pkg::OFS_IRQ_FLAGS, 16'h1c1c, "flags");
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h2283);
		for (int m = 2; m < 5; m++)
			rdc(ra(m), {log_data[m], 4'h0}, "result");
		wr(adcsq_pkg::OFS_IRQ_FLAGS, 16'h0004);
		rdc(adcsq_pkg::OFS_IRQ_FLAGS, 16'h1c18, "flags");
		wr(adcsq_pkg::OFS_IRQ_ENABLES, 16'h00e7);
		rdc(adcsq_pkg::OFS_IRQ_ENABLES, 16'h00e7, "enables");
		chk("irq", 16'h0000, 16'(o_irq));
		wr(adcsq_pkg::OFS_IRQ_ENABLES, 16'h1000);
		rd(adcsq_pkg::OFS_IRQ_FLAGS);
		chk("irq", 16'h0001, 16'(o_irq));
		wr(adcsq_pkg::OFS_IRQ_ENABLES, 16'h0000);
		wr(adcsq_pkg::OFS_IRQ_FLAGS, 16'hffff);
		rdc(adcsq_pkg::OFS_IRQ_FLAGS, 16'h0000, "flags");
	endtask

	// Timer trigger, continuous over inputs six and seven, then a forced stop.
	task automatic t_continuous();
		logic [2:0] last;
		int n;
		seen.delete();
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0001);
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h3e50);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		repeat (10) @(posedge i_clock);
		chk("request count", 16'h0000, 16'(seen.size()));
		pulse_timer();
		wait_starts(5);
		pulse_timer();
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0001);
		wait_idle();
		n = seen.size();
		repeat (20) @(posedge i_clock);
		chk("request count", 16'(n), 16'(seen.size()));
		for (int m = 0; m < n; m++)
			chk("channel", 16'(6 + m % 2), 16'(seen[m]));
		last = seen[n - 1];
		rdc(adcsq_pkg::OFS_CONV_CONTROL, {1'b0, (last == 3'h7) ? 3'h0 : last, 12'h001},
			"control");
		chk("sample", 16'h0004, 16'(smp));
	endtask

	// External pin: an edge blocked by range zero, a start write blocked by reserved select, then two edges, the second while busy.
	task automatic t_external();
		seen.delete();
		slow = 1'b1;
		wr(adcsq_pkg::OFS_CONV_CONFIG, 16'h0000);
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h0030);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		ext_pin_n <= 1'b0;
		repeat (10) @(posedge i_clock);
		ext_pin_n <= 1'b1;
		chk("request count", 16'h0000, 16'(seen.size()));
		wr(adcsq_pkg::OFS_CONV_CONFIG, 16'h0003);
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h0020);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0001);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		repeat (10) @(posedge i_clock);
		chk("request count", 16'h0000, 16'(seen.size()));
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0001);
		wr(adcsq_pkg::OFS_TRIGGER_INPUT_SELECT, 16'h0030);
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0003);
		ext_pin_n <= 1'b0;
		wait_starts(1);
		ext_pin_n <= 1'b1;
		repeat (2) @(posedge i_clock);
		ext_pin_n <= 1'b0;
		wait_idle();
		repeat (20) @(posedge i_clock);
		chk("request count", 16'h0001, 16'(seen.size()));
		wr(adcsq_pkg::OFS_CONV_CONTROL, 16'h0000);
		rdc(adcsq_pkg::OFS_CONV_CONTROL, 16'h0000, "control");
		chk("clock enable", 16'h0000, 16'(o_core_clock_en));
	endtask

	// Reset for twelve cycles, then the scenarios in turn.
	initial begin
		repeat (12) @(posedge i_clock);
		i_rst <= 1'b0;
		t_reset();
		t_one_shot();
		t_overwrite();
		t_continuous();
		t_external();
		conclude();
	end
endmodule // testbench
